/* File: logic/csc_pkg.sv */
// csc_pkg: shared constants and carrier types for the sensing channel select block
// assumes a 32-bit apb register bus and one system clock
package csc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CSC_ADDR_CHANNEL_CONTROL = 12'h000;
  localparam logic [11:0] CSC_ADDR_MODULE_CONTROL  = 12'h004;
  localparam logic [11:0] CSC_ADDR_ROUTE_STATUS    = 12'h008;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CSC_SEL_LSB         = 0;
  localparam int          CSC_SEL_WIDTH       = 4;
  localparam int          CSC_ENABLE_BIT      = 0;
  localparam int          CSC_ROUTE_VALID_BIT = 4;
  localparam logic [3:0]  CSC_SEL_RESET       = 4'h0;
  localparam logic        CSC_ENABLE_RESET    = 1'b0;
  localparam int          CSC_NUM_INPUTS      = 16;
  localparam int          CSC_REDUCED_INPUTS  = 8;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csc_apb_req_type;

  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } csc_apb_rsp_type;

endpackage : csc_pkg

/* File: logic/csc_apb_slave.sv */
// csc_apb_slave: apb register front end for the channel select block
// assumes apb3 master on clk_sys; answers after one wait state, pready a one-cycle pulse
`timescale 1ns/10ps
module csc_apb_slave
  import csc_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            clk_en,
  input  wire csc_apb_req_type apb_req,
  output csc_apb_rsp_type      apb_rsp,
  output logic                 wr_stb,
  output logic [11:0]          wr_addr,
  output logic [31:0]          wr_data,
  output logic [11:0]          rd_addr,
  input  wire logic [31:0]     rd_data
);

  typedef struct packed
  {
    csc_apb_rsp_type rsp;
  } csc_slv_state_type;

  csc_slv_state_type state_q;
  csc_slv_state_type state_d;

  // ----------------------------------------------------------------
  // decode: access phase completes in two cycles, one wait state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d             = state_q;
    state_d.rsp.pready  = 1'b0;
    state_d.rsp.pslverr = 1'b0;
    // pready pulses at the second edge of the access phase
    if (apb_req.psel && apb_req.penable && !state_q.rsp.pready)
    begin
      state_d.rsp.pready  = 1'b1;
      state_d.rsp.pslverr = !(apb_req.paddr == CSC_ADDR_CHANNEL_CONTROL ||
                              apb_req.paddr == CSC_ADDR_MODULE_CONTROL ||
                              apb_req.paddr == CSC_ADDR_ROUTE_STATUS);
      state_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_q <= '0;
    else if (clk_en)
      state_q <= state_d;
  end

  // write takes effect at the edge where pready is sampled high
  assign wr_stb  = apb_req.psel && apb_req.penable && state_q.rsp.pready && apb_req.pwrite && clk_en;
  assign wr_addr = apb_req.paddr;
  assign wr_data = apb_req.pwdata;
  assign rd_addr = apb_req.paddr;
  assign apb_rsp = state_q.rsp;

endmodule : csc_apb_slave

/* File: logic/csc_route_decoder.sv */
// csc_route_decoder: one-hot steering of the sensing oscillator onto one input
// assumes select and enable are the top's next-state values for flops on the same clock
`timescale 1ns/10ps
module csc_route_decoder
  import csc_pkg::*;
#(
  parameter int NUM_INPUTS = CSC_NUM_INPUTS
)
(
  input  wire logic                  enable,
  input  wire logic [3:0]            sel,
  output logic [NUM_INPUTS-1:0]      route
);

  // ----------------------------------------------------------------
  // per-input compare
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_route
      assign route[gi] = enable && (sel == 4'(gi));
    end
  endgenerate

endmodule : csc_route_decoder

/* File: logic/csc_channel_select.sv */
// csc_channel_select: top of the capacitive sensing channel select block
// assumes an apb master on clk_sys and an analog mux driven by sense_inputs_route
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
module csc_channel_select
  import csc_pkg::*;
#(
  parameter int NUM_INPUTS = CSC_NUM_INPUTS
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [NUM_INPUTS-1:0]    sense_inputs_route,
  output logic                     sense_module_enable
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // sixteen inputs max
  if (NUM_INPUTS != CSC_NUM_INPUTS && NUM_INPUTS != CSC_REDUCED_INPUTS)
  begin : g_bad_inputs
    $error("NUM_INPUTS must be 8 or 16");
  end

  localparam bit          REDUCED  = (NUM_INPUTS == CSC_REDUCED_INPUTS);
  localparam logic [3:0]  SEL_MASK = REDUCED ? 4'h7 : 4'hf;

  typedef struct packed
  {
    logic [3:0]            sel;
    logic                  enable;
    logic [NUM_INPUTS-1:0] route;
  } csc_top_state_type;

  csc_top_state_type state_q;
  csc_top_state_type state_d;

  csc_apb_req_type       apb_req;
  csc_apb_rsp_type       apb_rsp;
  logic                  wr_stb;
  logic [11:0]           wr_addr;
  logic [31:0]           wr_data;
  logic [11:0]           rd_addr;
  logic [31:0]           rd_data;
  logic [NUM_INPUTS-1:0] route_next;
  logic [3:0]            sel_next;
  logic                  enable_next;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  assign apb_req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  csc_apb_slave u_apb
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clk_en  (clk_en),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      CSC_ADDR_CHANNEL_CONTROL: rd_data[CSC_SEL_LSB +: CSC_SEL_WIDTH] = state_q.sel;
      CSC_ADDR_MODULE_CONTROL:  rd_data[CSC_ENABLE_BIT] = state_q.enable;
      CSC_ADDR_ROUTE_STATUS:
      begin
        // valid bit from the live route; the input index is the select register
        rd_data[CSC_ROUTE_VALID_BIT] = |state_q.route;
        rd_data[CSC_SEL_LSB +: CSC_SEL_WIDTH] = state_q.sel;
      end
      default:                  rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next select and enable, kept apart from state_d so the decoder
  // does not close a loop through the state copy
  // ----------------------------------------------------------------
  // upper bits dropped
  assign sel_next    = (wr_stb && wr_addr == CSC_ADDR_CHANNEL_CONTROL) ?
                       (wr_data[CSC_SEL_LSB +: CSC_SEL_WIDTH] & SEL_MASK) : state_q.sel;
  assign enable_next = (wr_stb && wr_addr == CSC_ADDR_MODULE_CONTROL) ?
                       wr_data[CSC_ENABLE_BIT] : state_q.enable;

  // ----------------------------------------------------------------
  // route decode from next-state values so route tracks in same edge
  // ----------------------------------------------------------------
  csc_route_decoder #(.NUM_INPUTS(NUM_INPUTS)) u_dec
  (
    .enable (enable_next),
    .sel    (sel_next),
    .route  (route_next)
  );

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d        = state_q;
    state_d.sel    = sel_next;
    state_d.enable = enable_next;
    state_d.route  = route_next;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q.sel    <= CSC_SEL_RESET;
      state_q.enable <= CSC_ENABLE_RESET;
      state_q.route  <= '0;
    end
    else if (clk_en)
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------------
  assign prdata              = apb_rsp.prdata;
  assign pready              = apb_rsp.pready;
  assign pslverr             = apb_rsp.pslverr;
  assign sense_inputs_route  = state_q.route;
  assign sense_module_enable = state_q.enable;

endmodule : csc_channel_select

/* File: dv/csc_chk_properties.sv */
// csc_chk: port-level checks for the channel select top
// assumes one clock, reset high, bound onto the top
`timescale 1ns/10ps
module csc_chk
  import csc_pkg::*;
#(
  parameter int NUM_INPUTS = 16
)
(
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  clk_en,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [NUM_INPUTS-1:0] sense_inputs_route,
  input wire logic                  sense_module_enable
);
  // --------------------------------------------------------------
  // handshake steps
  // --------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable && clk_en && !pready;
  endsequence
  // reads and writes of the channel control word
  wire rd0 = pready && !pwrite && paddr == 12'h000;
  wire wr0 = pready && pwrite && clk_en && paddr == 12'h000;
  chk_ready_wait: assert property (s_setup ##1 s_acc |=> pready)
    else $error("no ready after access");
  chk_ready_pulse: assert property (pready && clk_en |=> !pready)
    else $error("ready held too long");
  chk_off_none: assert property (!sense_module_enable |-> sense_inputs_route == '0)
    else $error("input routed while off");
  chk_on_onehot: assert property (sense_module_enable |-> $onehot(sense_inputs_route))
    else $error("route not one-hot");
  chk_upper_zero: assert property (rd0 |-> prdata[31:4] == '0)
    else $error("upper bits not zero");
  chk_read_route: assert property (rd0 && sense_module_enable |-> sense_inputs_route[prdata[3:0]])
    else $error("route differs from select");
  chk_write_move: assert property (wr0 && sense_module_enable
    |=> sense_inputs_route == NUM_INPUTS'(1) << ($past(pwdata[3:0]) % NUM_INPUTS))
    else $error("route did not follow write");
  chk_reduced_top: assert property (NUM_INPUTS <= 8 && rd0 |-> !prdata[3])
    else $error("select msb set on small part");
  chk_unmapped_err: assert property (pready && !(paddr inside {12'h000, 12'h004, 12'h008})
    |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  chk_enable_mirror: assert property (pready && !pwrite && paddr == 12'h004
    |-> prdata[0] == sense_module_enable) else $error("enable readback wrong");
  chk_reset_clear: assert property ($fell(rst) |-> sense_inputs_route == '0 && !sense_module_enable)
    else $error("state not clear after reset");
endmodule : csc_chk

bind csc_channel_select csc_chk #(.NUM_INPUTS(NUM_INPUTS)) chk_u (.clk_sys, .rst, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sense_inputs_route, .sense_module_enable);

/* File: dv/testbench.sv */
// testbench: random and corner apb traffic for the channel select top
// assumes the checker is bound in from its own file
`timescale 1ns/10ps
module testbench;
  import csc_pkg::*;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        clk_en = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r, d;
  logic        pready, pslverr, e, en;
  logic [15:0] sense_inputs_route;
  logic        sense_module_enable;
  logic [31:0] prdata_s, r_s;
  logic        pready_s, pslverr_s, e_s, enable_s;
  logic [7:0]  route_s;
  logic [3:0]  sel;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          seed = 43611;
  // ----------------------------------------------------------------
  // clock and device
  // ----------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  csc_channel_select dut_u (.clk_sys, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sense_inputs_route, .sense_module_enable);
  // reduced variant on the same bus inputs; same logic, so it answers in the same cycle
  csc_channel_select #(.NUM_INPUTS(CSC_REDUCED_INPUTS)) dut_small_u (.clk_sys, .rst, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s),
    .sense_inputs_route(route_s), .sense_module_enable(enable_s));
  // verdict, printed in one place only
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer; waits for ready, never a fixed count
  task automatic apb(logic w, logic [11:0] a, logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1;
    // only the watchdog ends a wait that never sees ready
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    r_s = prdata_s;
    e_s = pslverr_s;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic logic [31:0] e_route(logic on, logic [3:0] s);
    return on ? 32'(16'h0001 << s) : 32'h0000_0000;
  endfunction : e_route
  // route sampled mid-cycle, then the select read back
  task automatic chk_state;
    @(negedge clk_sys);
    cmp(32'(sense_inputs_route), e_route(en, sel));
    cmp(32'(route_s), e_route(en, {1'b0, sel[2:0]}));
    cmp({30'h0, enable_s, sense_module_enable}, {30'h0, en, en});
    apb(0, 12'h000, 32'h0000_0000);
    cmp(r, {28'h0, sel});
    cmp(r_s, {29'h0, sel[2:0]});
    cmp({30'h0, e_s, e}, 32'h0000_0000);
  endtask : chk_state
  task automatic wr_sel(logic [31:0] wd);
    apb(1, 12'h000, wd);
    sel = wd[3:0];
    chk_state;
  endtask : wr_sel
  task automatic wr_en(logic b);
    apb(1, 12'h004, {31'h0, b});
    en = b;
    chk_state;
  endtask : wr_en
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sel = 0;
    en = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    chk_state;
    wr_sel(32'hFFFF_FFF9);
    wr_en(1);
    for (int i = 0; i < 16; i++)
      wr_sel(($random(seed) & 32'hFFFF_FFF0) | i);
    for (int i = 0; i < 30; i++)
    begin
      d = $random(seed);
      if (d[1:0] == 2'h0)
        wr_en(d[2]);
      else
        wr_sel(d);
    end
    wr_en(1);
    apb(1, 12'h00C, 32'h0000_0003);
    cmp({31'h0, e}, 32'h0000_0001);
    cmp({31'h0, e_s}, 32'h0000_0001);
    apb(0, 12'h00C, 32'h0000_0000);
    cmp(r, 32'h0000_0000);
    apb(0, 12'h008, 32'h0000_0000);
    cmp(r, {27'h0, en, sel});
    apb(0, 12'h004, 32'h0000_0000);
    cmp(r, {31'h0, en});
    // a low clock enable holds a write in its access phase; it lands once the enable returns
    d = $random(seed);
    fork
      apb(1, 12'h000, d);
      begin
        clk_en <= 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        cmp({31'h0, pready}, 32'h0000_0000);
        cmp(32'(sense_inputs_route), e_route(en, sel));
        @(posedge clk_sys);
        clk_en <= 1;
      end
    join
    sel = d[3:0];
    chk_state;
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    sel = 0;
    en = 0;
    chk_state;
    stop_test;
  end
  // watchdog far beyond the few hundred cycles of traffic
  initial
  begin
    #100000;
    fail_count++;
    stop_test;
  end
endmodule : testbench
